// ---- inc/sbl_pkg.sv ----
// Purpose: Constants and types shared by the serial boot loader
// Assumes: One system clock, one state is one clock cycle
// Notes: Divisor is counted in system clock cycles per bit
package sbl_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int STARTUP_STATES = 100;
  localparam int STARTUP_CYCLES = STARTUP_STATES;
  localparam int MODE_LATCH_CYCLE = 4;
  localparam int MEAS_COUNT = 4;
  localparam int BITS_PER_LOW = 9;
  localparam int RATE_HI_BPS = 9600;
  localparam int RATE_LO_BPS = 4800;
  localparam int HI_MIN_HZ = 8_000_000;
  localparam int LO_MIN_HZ = 4_000_000;
  localparam int MAX_HZ = 18_000_000;
  localparam logic [11:0] RATE_SPLIT = 12'(CLK_HZ / 7200);
  localparam logic OK_HI = (CLK_HZ >= HI_MIN_HZ) && (CLK_HZ <= MAX_HZ);
  localparam logic OK_LO = (CLK_HZ >= LO_MIN_HZ) && (CLK_HZ <= MAX_HZ);
  // ==========================================================
  // Bytes and memory map
  localparam logic [7:0] BYTE_ADJ_DONE = 8'h00;
  localparam logic [7:0] BYTE_SYNC = 8'h55;
  localparam logic [7:0] BYTE_ACK = 8'hAA;
  localparam logic [7:0] BYTE_ERASE_ERR = 8'hFF;
  localparam logic [19:0] RAM_BASE = 20'hFF300;
  localparam logic [15:0] RAM_AREA_BYTES = 16'hC00;
  // ==========================================================
  // Reset values
  localparam logic [11:0] DIV_RST = 12'h000;
  localparam logic [2:0] MODE_RST = 3'h0;
  // ==========================================================
  // Loader states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_WAIT = 4'h1, ST_MEAS = 4'h3, ST_CALC = 4'h2,
    ST_SEND_ADJ = 4'h6, ST_GET_SYNC = 4'h7, ST_SEND_ACK = 4'h5,
    ST_LEN_HI = 4'h4, ST_LEN_LO = 4'hC, ST_DATA = 4'hD, ST_CHECK = 4'hF,
    ST_ERASE = 4'hE, ST_SEND_OK = 4'hA, ST_RUN = 4'hB, ST_HALT = 4'h9
  } sbl_state_t;
endpackage

// ---- verilog/sbl_loader.sv ----
// Purpose: Boot mode selection, bit rate detection and program load
// Assumes: Host keeps its side of the boot handshake
// Notes: Flash erase itself is done by an external engine
//
// Contract
// - Mode 6 pins never enter boot or user program mode.
// - Boot when write enable and low mode pin high and high mode pin low; user when high.
// - Mode control register reports mode 5 or 7 while in boot mode.
// - Boot erase covers whole flash at once, leaving all ones.
// - User program mode allows block erase only, no byte erase.
// - Only the one asynchronous serial channel talks to the host.
// - Time low intervals repeatedly and load derived bit rate divisor.
// - Send one zero byte when bit rate adjustment ends.
// - Answer 0x55 with 0xAA; host sends length high first, then program.
// - Echo every length and program byte back to the host.
// - Store program bytes in sequence into the RAM transfer window.
// - If flash is not blank before running, erase all blocks.
// - On erase failure send one 0xFF byte and halt.
// - After final 0xAA jump to first RAM transfer address.
// - Detection is guaranteed only within listed clock ranges per rate.
// - Reset released with receive line high; wait 100 states first.
// - Before jump disable serial, keep divisor, drive transmit high.
`timescale 1ns/1ps
module sbl_loader
  import sbl_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  // Mode pins
  input wire logic I_FLASH_WRITE_ENABLE_PIN,
  input wire logic I_MODE_SELECT_PIN_HIGH,
  input wire logic I_MODE_SELECT_PIN_MID,
  input wire logic I_MODE_SELECT_PIN_LOW,
  // Serial link
  input wire logic I_BOOT_RECEIVE_PIN,
  output logic O_BOOT_TRANSMIT_PIN,
  // Mode and rate status
  output logic [2:0] O_MODE_CONTROL_REGISTER,
  output logic O_BOOT_MODE,
  output logic O_USER_PROGRAM_MODE,
  output logic [11:0] O_BIT_RATE_REGISTER,
  output logic O_RATE_GUARANTEED,
  output logic O_SERIAL_EN,
  // RAM write port
  output logic O_RAM_WE,
  output logic [19:0] O_RAM_ADDR,
  output logic [7:0] O_RAM_WDATA,
  // Flash control
  input wire logic I_FLASH_BLANK,
  input wire logic I_FLASH_ERASE_DONE,
  input wire logic I_FLASH_ERASE_FAIL,
  output logic O_FLASH_ERASE_ALL,
  output logic O_BLOCK_ERASE_EN,
  // Program start
  output logic O_JUMP,
  output logic [19:0] O_JUMP_ADDR,
  output logic O_HALTED
);
  // ==========================================================
  // Declarations
  logic [4:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic rx_ff;
  logic [7:0] start_cnt_ff;
  logic boot_ff, user_ff;
  logic [2:0] mode_ff;
  sbl_state_t state_ff, nxt_state;
  logic [19:0] low_cnt_ff, sum_ff;
  logic [2:0] meas_ff;
  logic [11:0] div_ff, quot_ff;
  logic rx_busy_ff, rx_done_ff;
  logic [11:0] rx_cnt_ff;
  logic [3:0] rx_idx_ff;
  logic [7:0] rx_sh_ff, rx_data_ff;
  logic tx_busy_ff, sent_ff, tx_pin_ff;
  logic [11:0] tx_cnt_ff;
  logic [3:0] tx_idx_ff;
  logic [9:0] tx_sh_ff;
  logic tx_go, send_state, echo_state, rx_en, last_byte;
  logic [7:0] tx_byte;
  logic [15:0] len_ff, idx_ff;
  logic erase_ff, jump_ff, we_ff;
  logic [19:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [19:0] div_step;

  // ==========================================================
  // Pin synchronisers, change taken once stages 2 and 3 agree
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_s1_ff <= 5'h1F;
      pin_s2_ff <= 5'h1F;
      pin_s3_ff <= 5'h1F;
    end else begin
      pin_s1_ff <= {I_BOOT_RECEIVE_PIN, I_FLASH_WRITE_ENABLE_PIN,
                    I_MODE_SELECT_PIN_HIGH, I_MODE_SELECT_PIN_MID,
                    I_MODE_SELECT_PIN_LOW};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_ff <= 1'b1;
    end else if (pin_s2_ff[4] == pin_s3_ff[4]) begin
      rx_ff <= pin_s3_ff[4];
    end
  end

  // ==========================================================
  // Mode latch after reset release
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      start_cnt_ff <= 8'h00;
    end else if (start_cnt_ff != 8'(STARTUP_CYCLES)) begin
      start_cnt_ff <= start_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      boot_ff <= 1'b0;
      user_ff <= 1'b0;
      mode_ff <= MODE_RST;
    end else if (start_cnt_ff == 8'(MODE_LATCH_CYCLE) && pin_s2_ff == pin_s3_ff) begin
      boot_ff <= pin_s3_ff[3] & ~pin_s3_ff[2] & pin_s3_ff[0];
      user_ff <= pin_s3_ff[3] & pin_s3_ff[2] & pin_s3_ff[0];
      // high pin read inverted in boot
      mode_ff <= {pin_s3_ff[2] ^ (pin_s3_ff[3] & ~pin_s3_ff[2] & pin_s3_ff[0]),
                  pin_s3_ff[1], pin_s3_ff[0]};
    end
  end

  // ==========================================================
  // Loader sequence
  assign send_state = (state_ff == ST_SEND_ADJ) || (state_ff == ST_SEND_ACK) ||
                      (state_ff == ST_SEND_OK) || (state_ff == ST_HALT);
  assign echo_state = (state_ff == ST_LEN_HI) || (state_ff == ST_LEN_LO) ||
                      (state_ff == ST_DATA);
  assign rx_en = (state_ff == ST_GET_SYNC) || echo_state;
  assign last_byte = (idx_ff + 16'h0001) == len_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (boot_ff) nxt_state = ST_WAIT;
      ST_WAIT: if (start_cnt_ff == 8'(STARTUP_CYCLES) && rx_ff) nxt_state = ST_MEAS;
      ST_MEAS: if (meas_ff == 3'(MEAS_COUNT)) nxt_state = ST_CALC;
      ST_CALC: if (sum_ff < div_step) nxt_state = ST_SEND_ADJ;
      ST_SEND_ADJ, ST_SEND_ACK: if (sent_ff && !tx_busy_ff) nxt_state = sbl_state_t'(
        (state_ff == ST_SEND_ADJ) ? ST_GET_SYNC : ST_LEN_HI);
      ST_GET_SYNC: if (rx_done_ff && rx_data_ff == BYTE_SYNC) nxt_state = ST_SEND_ACK;
      ST_LEN_HI: if (rx_done_ff) nxt_state = ST_LEN_LO;
      ST_LEN_LO: if (rx_done_ff) nxt_state = ({len_ff[15:8], rx_data_ff} == 16'h0000) ?
        ST_CHECK : ST_DATA;
      ST_DATA: if (rx_done_ff && last_byte) nxt_state = ST_CHECK;
      ST_CHECK: if (!tx_busy_ff) nxt_state = I_FLASH_BLANK ? ST_SEND_OK : ST_ERASE;
      ST_ERASE: if (I_FLASH_ERASE_DONE) nxt_state = I_FLASH_ERASE_FAIL ? ST_HALT : ST_SEND_OK;
      ST_SEND_OK: if (sent_ff && !tx_busy_ff) nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      ST_HALT: nxt_state = ST_HALT;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) state_ff <= ST_IDLE;
    else state_ff <= nxt_state;
  end

  // ==========================================================
  // Low period timing and divisor
  // nine bit times per low
  assign div_step = 20'(MEAS_COUNT * BITS_PER_LOW);

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      low_cnt_ff <= 20'h00000;
      sum_ff <= 20'h00000;
      meas_ff <= 3'h0;
      quot_ff <= 12'h000;
    end else if (state_ff == ST_MEAS) begin
      if (!rx_ff) begin
        low_cnt_ff <= low_cnt_ff + 20'h00001;
      end else if (low_cnt_ff != 20'h00000) begin
        sum_ff <= sum_ff + low_cnt_ff;
        meas_ff <= meas_ff + 3'h1;
        low_cnt_ff <= 20'h00000;
      end
    end else if (state_ff == ST_CALC && sum_ff >= div_step) begin
      sum_ff <= sum_ff - div_step;
      quot_ff <= quot_ff + 12'h001;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      div_ff <= DIV_RST;
    end else if (state_ff == ST_CALC && sum_ff < div_step) begin
      div_ff <= quot_ff;
    end
  end

  // ==========================================================
  // Receiver, 8N1
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_busy_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_cnt_ff <= 12'h000;
      rx_idx_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_data_ff <= 8'h00;
    end else begin
      rx_done_ff <= 1'b0;
      if (!rx_en) begin
        rx_busy_ff <= 1'b0;
      end else if (!rx_busy_ff) begin
        if (!rx_ff) begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff <= {1'b0, div_ff[11:1]};
          rx_idx_ff <= 4'h0;
        end
      end else if (rx_cnt_ff != 12'h000) begin
        rx_cnt_ff <= rx_cnt_ff - 12'h001;
      end else begin
        rx_cnt_ff <= div_ff - 12'h001;
        rx_idx_ff <= rx_idx_ff + 4'h1;
        if (rx_idx_ff == 4'h0 && rx_ff) rx_busy_ff <= 1'b0;
        if (rx_idx_ff != 4'h0 && rx_idx_ff != 4'h9) rx_sh_ff <= {rx_ff, rx_sh_ff[7:1]};
        if (rx_idx_ff == 4'h9) begin
          rx_busy_ff <= 1'b0;
          rx_done_ff <= rx_ff;
          rx_data_ff <= rx_sh_ff;
        end
      end
    end
  end

  // ==========================================================
  // Transmitter, 8N1
  always_comb begin
    unique case (state_ff)
      ST_SEND_ACK, ST_SEND_OK: tx_byte = BYTE_ACK;
      ST_HALT: tx_byte = BYTE_ERASE_ERR;
      ST_SEND_ADJ: tx_byte = BYTE_ADJ_DONE;
      default: tx_byte = rx_data_ff;
    endcase
  end

  assign tx_go = !tx_busy_ff && ((send_state && !sent_ff) || (echo_state && rx_done_ff));

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) sent_ff <= 1'b0;
    else if (nxt_state != state_ff) sent_ff <= 1'b0;
    else if (tx_go) sent_ff <= 1'b1;
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_busy_ff <= 1'b0;
      tx_cnt_ff <= 12'h000;
      tx_idx_ff <= 4'h0;
      tx_sh_ff <= 10'h3FF;
      tx_pin_ff <= 1'b1;
    end else if (tx_go) begin
      tx_busy_ff <= 1'b1;
      tx_sh_ff <= {1'b1, tx_byte, 1'b0};
      tx_cnt_ff <= div_ff - 12'h001;
      tx_idx_ff <= 4'h0;
      tx_pin_ff <= 1'b0;
    end else if (tx_busy_ff) begin
      if (tx_cnt_ff != 12'h000) begin
        tx_cnt_ff <= tx_cnt_ff - 12'h001;
      end else if (tx_idx_ff == 4'h9) begin
        tx_busy_ff <= 1'b0;
        tx_pin_ff <= 1'b1;
      end else begin
        tx_cnt_ff <= div_ff - 12'h001;
        tx_idx_ff <= tx_idx_ff + 4'h1;
        tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
        tx_pin_ff <= tx_sh_ff[1];
      end
    end else begin
      tx_pin_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Length, RAM store, erase and jump
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      len_ff <= 16'h0000;
      idx_ff <= 16'h0000;
      we_ff <= 1'b0;
      addr_ff <= RAM_BASE;
      wdata_ff <= 8'h00;
    end else begin
      we_ff <= 1'b0;
      if (state_ff == ST_LEN_HI && rx_done_ff) len_ff[15:8] <= rx_data_ff;
      if (state_ff == ST_LEN_LO && rx_done_ff) len_ff[7:0] <= rx_data_ff;
      if (state_ff == ST_DATA && rx_done_ff) begin
        idx_ff <= idx_ff + 16'h0001;
        we_ff <= idx_ff < RAM_AREA_BYTES;
        addr_ff <= RAM_BASE + {4'h0, idx_ff};
        wdata_ff <= rx_data_ff;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      erase_ff <= 1'b0;
      jump_ff <= 1'b0;
    end else begin
      erase_ff <= (state_ff == ST_CHECK) && (nxt_state == ST_ERASE);
      jump_ff <= (state_ff == ST_SEND_OK) && (nxt_state == ST_RUN);
    end
  end

  // ==========================================================
  // Outputs
  assign O_BOOT_TRANSMIT_PIN = tx_pin_ff;
  assign O_MODE_CONTROL_REGISTER = mode_ff;
  assign O_BOOT_MODE = boot_ff;
  assign O_USER_PROGRAM_MODE = user_ff;
  assign O_BIT_RATE_REGISTER = div_ff;
  assign O_RATE_GUARANTEED = (div_ff < RATE_SPLIT) ? OK_HI : OK_LO;
  assign O_SERIAL_EN = boot_ff && (state_ff != ST_RUN) && (state_ff != ST_HALT || tx_busy_ff);
  assign O_RAM_WE = we_ff;
  assign O_RAM_ADDR = addr_ff;
  assign O_RAM_WDATA = wdata_ff;
  assign O_FLASH_ERASE_ALL = erase_ff;
  // block erase only in user mode
  assign O_BLOCK_ERASE_EN = user_ff;
  assign O_JUMP = jump_ff;
  assign O_JUMP_ADDR = RAM_BASE;
  assign O_HALTED = (state_ff == ST_HALT);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  mode_excl_a: assert property (!(boot_ff && user_ff))
    else $error("boot and user mode both set");
  boot_pins_a: assert property (boot_ff |-> mode_ff[2] && mode_ff[0])
    else $error("boot mode reports wrong mode");
  startup_wait_a: assert property (state_ff == ST_MEAS |-> start_cnt_ff == 8'd100)
    else $error("timing began too early");
  div_load_a: assert property ($changed(div_ff) |-> $past(state_ff) == ST_CALC)
    else $error("divisor changed outside calc");
  adj_byte_a: assert property (tx_go && state_ff == ST_SEND_ADJ |-> tx_byte == 8'h00)
    else $error("adjust end byte wrong");
  echo_a: assert property (echo_state && rx_done_ff && !tx_busy_ff |=> tx_sh_ff[8:1] == $past(rx_data_ff))
    else $error("echo byte mismatch");
  ram_addr_a: assert property (we_ff |-> addr_ff >= 20'hFF300 && addr_ff < 20'hFFF00)
    else $error("RAM write outside window");
  erase_err_a: assert property (state_ff == ST_ERASE && I_FLASH_ERASE_DONE && I_FLASH_ERASE_FAIL |=> ##[1:3] tx_busy_ff && tx_sh_ff[8:1] == 8'hFF)
    else $error("erase error byte missing");
  jump_clean_a: assert property (jump_ff |=> !O_SERIAL_EN && tx_pin_ff && $stable(div_ff))
    else $error("serial still on after jump");
  jump_addr_a: assert property (jump_ff |-> $past(state_ff) == ST_SEND_OK && O_JUMP_ADDR == 20'hFF300)
    else $error("jump without final ack");

  sync_seen_c: cover property (state_ff == ST_GET_SYNC ##1 state_ff == ST_SEND_ACK);
  erase_run_c: cover property (state_ff == ST_ERASE ##1 state_ff == ST_SEND_OK);
  halt_c: cover property (state_ff == ST_ERASE ##1 state_ff == ST_HALT);
  run_c: cover property (jump_ff);
endmodule

// ---- testbench/sbl_host_model.sv ----
// Purpose: Host side of the boot serial link
// Assumes: Link idles high through the board pull-up
// Notes: Bit time is counted in bench clock cycles
`timescale 1ns/1ps
module sbl_host_model #(
  parameter int BIT_CYC = 1042
) (
  // Clock
  input wire logic i_clk,
  // Serial link
  input wire logic i_dev_tx,
  output logic o_host_tx
);
  logic rx_active;

  initial begin
    o_host_tx = 1'b1;
    rx_active = 1'b0;
  end

  // ==========================================================
  // Transmit one frame
  // eight bits one stop
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_host_tx <= frame[i];
      repeat (BIT_CYC) @(posedge i_clk);
    end
    repeat (gap) @(posedge i_clk);
  endtask

  // ==========================================================
  // Receive one frame, returns at mid stop bit
  task automatic recv_byte(output logic [7:0] b);
    @(negedge i_dev_tx);
    rx_active = 1'b1;
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_clk);
      b[i] = i_dev_tx;
    end
    repeat (BIT_CYC) @(posedge i_clk);
  endtask

  // ==========================================================
  // Rate adjustment
  // zeros until answered
  task automatic sync_up(output logic [7:0] got);
    rx_active = 1'b0;
    fork
      while (!rx_active) send_byte(8'h00, 0);
      recv_byte(got);
    join
  endtask
endmodule

// ---- testbench/sbl_loader_bench.sv ----
// Purpose: Self-checking bench for the serial boot loader
// Assumes: Host at 9600 bps, system clock 10 MHz
// Notes: Flash erase engine is modelled in the bench
`timescale 1ns/1ps
module sbl_loader_bench
  import sbl_pkg::*;
;
  logic clk, rst, flash_write_enable_pin, md_hi, md_mid, md_lo, host_tx, dev_tx;
  logic flash_blank, erase_done, erase_fail;
  logic boot, user, rate_ok, ser_en, ram_we, erase_all, blk_en, jump, halted;
  logic [2:0] mode_reg;
  logic [11:0] div;
  logic [19:0] ram_addr, jump_addr;
  logic [7:0] ram_wdata;
  logic [7:0] sent [0:7];
  int mismatches, total_checks, ram_cnt, erase_cnt, jump_cnt;

  sbl_loader dut (
    .I_REF_CLK(clk), .I_SYS_RST(rst),
    .I_FLASH_WRITE_ENABLE_PIN(flash_write_enable_pin), .I_MODE_SELECT_PIN_HIGH(md_hi),
    .I_MODE_SELECT_PIN_MID(md_mid), .I_MODE_SELECT_PIN_LOW(md_lo),
    .I_BOOT_RECEIVE_PIN(host_tx), .O_BOOT_TRANSMIT_PIN(dev_tx),
    .O_MODE_CONTROL_REGISTER(mode_reg), .O_BOOT_MODE(boot),
    .O_USER_PROGRAM_MODE(user), .O_BIT_RATE_REGISTER(div),
    .O_RATE_GUARANTEED(rate_ok), .O_SERIAL_EN(ser_en),
    .O_RAM_WE(ram_we), .O_RAM_ADDR(ram_addr), .O_RAM_WDATA(ram_wdata),
    .I_FLASH_BLANK(flash_blank), .I_FLASH_ERASE_DONE(erase_done),
    .I_FLASH_ERASE_FAIL(erase_fail), .O_FLASH_ERASE_ALL(erase_all),
    .O_BLOCK_ERASE_EN(blk_en), .O_JUMP(jump), .O_JUMP_ADDR(jump_addr),
    .O_HALTED(halted)
  );

  sbl_host_model #(.BIT_CYC(1042)) host (
    .i_clk(clk), .i_dev_tx(dev_tx), .o_host_tx(host_tx)
  );

  // ==========================================================
  // Clock, checks and closing
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Expected {boot, user, mode register} for pins {fwe, hi, mid, lo}
  function automatic logic [4:0] exp_mode(input logic [3:0] p);
    logic bt, us;
    bt = p[3] && !p[2] && p[0];
    us = p[3] && p[2] && p[0];
    return {bt, us, p[2] ^ bt, p[1], p[0]};
  endfunction

  task automatic do_reset(input logic [3:0] pins);
    @(posedge clk);
    rst <= 1'b1;
    {flash_write_enable_pin, md_hi, md_mid, md_lo} <= pins;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask

  // ==========================================================
  // Flash erase engine and output monitors
  initial begin
    erase_done = 1'b0;
    forever begin
      @(posedge clk);
      if (erase_all === 1'b1) begin
        erase_cnt++;
        repeat (5 + $urandom % 50) @(posedge clk);
        erase_done <= 1'b1;
        @(posedge clk);
        erase_done <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (ram_we === 1'b1) begin
      check(32'(ram_addr), 32'(RAM_BASE) + 32'(ram_cnt));
      check(32'(ram_wdata), 32'(sent[ram_cnt + 2]));
      ram_cnt++;
    end
    if (jump === 1'b1) begin
      jump_cnt++;
      check(32'(jump_addr), 32'(RAM_BASE));
    end
  end

  // ==========================================================
  // Full boot session
  task automatic boot_run(input int n, input logic blank, input logic fail,
                          input logic [3:0] pins);
    logic [7:0] got;
    logic [11:0] div_seen;
    ram_cnt = 0;
    erase_cnt = 0;
    jump_cnt = 0;
    sent[0] = 8'h00;
    sent[1] = 8'(n);
    for (int i = 0; i < n; i++) sent[i + 2] = 8'($urandom);
    flash_blank <= blank;
    erase_fail <= fail;
    do_reset(pins);
    repeat (200) @(posedge clk);
    host.sync_up(got);
    check(32'(got), 32'(BYTE_ADJ_DONE));
    check(32'(div > 12'h406 && div < 12'h41D), 32'h1);
    check(32'(rate_ok), 32'(OK_HI));
    check(32'(ser_en), 32'h1);
    div_seen = div;
    // Let the adjust byte's stop bit end before the reply
    repeat (1100) @(posedge clk);
    fork
      host.send_byte(BYTE_SYNC, 0);
      host.recv_byte(got);
    join
    check(32'(got), 32'(BYTE_ACK));
    // Length may start only once the ack frame has ended
    repeat (1100) @(posedge clk);
    fork
      // length within area
      // Gap keeps each echo clear of the next byte
      for (int i = 0; i < n + 2; i++) host.send_byte(sent[i], 30 + $urandom % 70);
      for (int i = 0; i < n + 2; i++) begin
        host.recv_byte(got);
        check(32'(got), 32'(sent[i]));
      end
    join
    host.recv_byte(got);
    check(32'(got), 32'(fail ? BYTE_ERASE_ERR : BYTE_ACK));
    for (int k = 0; k < 3000 && jump_cnt == 0 && halted !== 1'b1; k++) @(posedge clk);
    repeat (2200) @(posedge clk);
    check(32'(erase_cnt), 32'(!blank));
    check(32'(blk_en), 32'h0);
    check(32'(ram_cnt), 32'(n));
    check(32'(halted), 32'(fail));
    check(32'(jump_cnt), 32'(!fail));
    check(32'(ser_en), 32'h0);
    check(32'(dev_tx), 32'h1);
    check(32'(div), 32'(div_seen));
    $display("boot session of %0d bytes done", n);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {flash_write_enable_pin, md_hi, md_mid, md_lo} = 4'h0;
    flash_blank = 1'b1;
    erase_fail = 1'b0;
    mismatches = 0;
    total_checks = 0;
    void'($urandom(18));
    for (int p = 0; p < 16; p++) begin
      do_reset(4'(p));
      repeat (10) @(posedge clk);
      check(32'(boot), 32'(exp_mode(4'(p)) >> 4));
      check(32'(user), 32'(exp_mode(4'(p)) >> 3) & 32'h1);
      check(32'(mode_reg), 32'(exp_mode(4'(p))) & 32'h7);
      check(32'(blk_en), 32'(exp_mode(4'(p)) >> 3) & 32'h1);
    end
    $display("mode selection done");
    boot_run(3, 1'b0, 1'b0, 4'hB);
    boot_run(0, 1'b1, 1'b0, 4'h9);
    boot_run(1, 1'b0, 1'b1, 4'hB);
    end_sim();
  end

  // Watchdog
  initial begin
    #60_000_000;
    mismatches++;
    end_sim();
  end
endmodule
